// >>> logic/pec_enable_control.sv
`timescale 1ns/1ps
`include "pec_params.svh"

module pec_enable_control
  import pec_pkg::*;
(
  input  wire logic                        ref_clk_in,
  input  wire logic                        reset_n_in,
  input  wire logic                        cpu_sel_in,
  input  wire logic                        cpu_wr_in,
  input  wire logic [`PEC_CPU_ADDR_W-1:0]  cpu_addr_in,
  input  wire logic [3:0]                  cpu_be_in,
  input  wire logic [31:0]                 cpu_wdata_in,
  output logic                             cpu_ack_out,
  output logic [31:0]                      cpu_rdata_out,
  input  wire logic                        pci_aob_sel_in,
  input  wire logic                        pci_aob_wr_in,
  output logic                             pci_aob_ack_out,
  output logic [31:0]                      pci_aob_rdata_out,
  input  wire logic                        serr_n_in,
  output logic                             arbiter_on_out,
  output logic                             add_on_mode_out,
  output logic                             target_retry_out,
  output logic                             inta_n_out,
  output logic                             inta_oe_n_out,
  output logic                             nmi_n_out
);

  logic        arbiter_on;
  logic        add_on_mode;
  logic        config_done;
  logic        int_pending;
  logic        nmi_n;
  logic        set_int_bit;
  logic        rst_nmi_bit;
  logic        serr_n_sync;
  logic        ctrl_hit;
  logic        ctrl_wr;
  logic        ctrl_rd;
  logic        set_int_evt;
  logic        rst_nmi_evt;
  logic        pci_clr_evt;
  logic        serr_seen;
  logic        next_int_pending;
  logic        next_nmi_n;
  logic        next_config_done;
  pec_word_t   ctrl_view;
  pec_access_t cpu_access;

  pec_sync3 u_serr_sync (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (serr_n_in),
    .sync_out   (serr_n_sync)
  );

  // CPU access decode
  assign ctrl_hit = cpu_sel_in && (cpu_addr_in == `PEC_OFS_ENABLE_CTRL);

  always_comb begin
    if (!ctrl_hit) begin
      cpu_access = PEC_ACC_IDLE;
    end else if (cpu_wr_in) begin
      cpu_access = PEC_ACC_WRITE;
    end else begin
      cpu_access = PEC_ACC_READ;
    end
  end

  always_comb begin
    ctrl_wr = 1'b0;
    ctrl_rd = 1'b0;
    unique case (cpu_access)
      PEC_ACC_IDLE: begin
        ctrl_wr = 1'b0;
      end
      PEC_ACC_READ: begin
        ctrl_rd = 1'b1;
      end
      PEC_ACC_WRITE: begin
        ctrl_wr = cpu_be_in[0];
      end
    endcase
  end

  // Events; add-on mode as held before this write
  assign set_int_evt = ctrl_wr && cpu_wdata_in[`PEC_BIT_SET_INT]
                       && add_on_mode;
  assign rst_nmi_evt = ctrl_wr && cpu_wdata_in[`PEC_BIT_RST_NMI]
                       && add_on_mode;
  assign pci_clr_evt = pci_aob_sel_in && pci_aob_wr_in;
  assign serr_seen   = !serr_n_sync;

  // Mode bits
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      arbiter_on  <= 1'b0;
      add_on_mode <= 1'b0;
    end else if (ctrl_wr) begin
      arbiter_on  <= cpu_wdata_in[`PEC_BIT_ARB_ON];
      add_on_mode <= cpu_wdata_in[`PEC_BIT_ADD_ON];
    end
  end

  // Configuration done gates target responses
  always_comb begin
    next_config_done = config_done;
    if (ctrl_wr) begin
      next_config_done = cpu_wdata_in[`PEC_BIT_CFG_DONE];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_done      <= 1'b0;
      target_retry_out <= 1'b1;
    end else begin
      config_done      <= next_config_done;
      target_retry_out <= !next_config_done;
    end
  end

  // Self-clearing command bits
  pec_pulse_bit u_set_int (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .set_in     (ctrl_wr && cpu_wdata_in[`PEC_BIT_SET_INT]),
    .bit_out    (set_int_bit)
  );

  pec_pulse_bit u_rst_nmi (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .set_in     (ctrl_wr && cpu_wdata_in[`PEC_BIT_RST_NMI]),
    .bit_out    (rst_nmi_bit)
  );

  // INTA# pending; a CPU set beats a PCI clear in the same cycle
  assign next_int_pending = set_int_evt || (int_pending && !pci_clr_evt);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_pending   <= 1'b0;
      inta_oe_n_out <= 1'b1;
    end else begin
      int_pending   <= next_int_pending;
      inta_oe_n_out <= !next_int_pending;
    end
  end

  // Open-drain INTA# only ever pulls low
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      inta_n_out <= 1'b0;
    end else begin
      inta_n_out <= 1'b0;
    end
  end

  // NMI#; a live SERR# beats a software clear
  assign next_nmi_n = !serr_seen && (nmi_n || rst_nmi_evt);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nmi_n     <= 1'b1;
      nmi_n_out <= 1'b1;
    end else begin
      nmi_n     <= next_nmi_n;
      nmi_n_out <= next_nmi_n;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      arbiter_on_out  <= 1'b0;
      add_on_mode_out <= 1'b0;
    end else begin
      arbiter_on_out  <= ctrl_wr ? cpu_wdata_in[`PEC_BIT_ARB_ON]
                                 : arbiter_on;
      add_on_mode_out <= ctrl_wr ? cpu_wdata_in[`PEC_BIT_ADD_ON]
                                 : add_on_mode;
    end
  end

  // Read view; bit 3 shows pending, not the stored command
  always_comb begin
    ctrl_view = `PEC_CTRL_RESET;
    ctrl_view[`PEC_BIT_ARB_ON]   = arbiter_on;
    ctrl_view[`PEC_BIT_ADD_ON]   = add_on_mode;
    ctrl_view[`PEC_BIT_CFG_DONE] = config_done;
    ctrl_view[`PEC_BIT_SET_INT]  = int_pending;
    ctrl_view[`PEC_BIT_RST_NMI]  = rst_nmi_bit;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_ack_out   <= 1'b0;
      cpu_rdata_out <= `PEC_CTRL_RESET;
    end else begin
      cpu_ack_out   <= ctrl_hit;
      cpu_rdata_out <= ctrl_rd ? ctrl_view : `PEC_CTRL_RESET;
    end
  end

  // Add-on interrupt register as seen from the PCI side
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pci_aob_ack_out   <= 1'b0;
      pci_aob_rdata_out <= `PEC_AOB_RESET;
    end else begin
      pci_aob_ack_out   <= pci_aob_sel_in;
      pci_aob_rdata_out <= `PEC_AOB_RESET;
      if (pci_aob_sel_in && !pci_aob_wr_in) begin
        pci_aob_rdata_out[`PEC_BIT_INT_PEND] <= int_pending;
      end
    end
  end

  default clocking pec_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence seq_cmd_write(int b);
    ctrl_wr && cpu_wdata_in[b];
  endsequence

  sequence seq_pulse_then_drop;
    set_int_bit ##1 !set_int_bit;
  endsequence

  chk_reset_clear: assert property (
    disable iff (1'b0)
    $rose(reset_n_in) |-> (!arbiter_on && !add_on_mode && !config_done
                           && target_retry_out && inta_oe_n_out))
    else $error("Control bits not clear after reset");

  chk_offset_decode: assert property (
    (cpu_sel_in && cpu_wr_in && cpu_addr_in != `PEC_OFS_ENABLE_CTRL)
    |=> $stable(arbiter_on) && $stable(add_on_mode) && $stable(config_done))
    else $error("Write to another offset changed control bits");

  chk_arb_follow: assert property (
    ctrl_wr |=> arbiter_on_out == $past(cpu_wdata_in[`PEC_BIT_ARB_ON]))
    else $error("Arbiter enable does not follow bit 0");

  chk_addon_follow: assert property (
    ctrl_wr |=> add_on_mode_out == $past(cpu_wdata_in[`PEC_BIT_ADD_ON]))
    else $error("Add-on mode does not follow bit 1");

  chk_retry_gate: assert property (
    target_retry_out == !config_done)
    else $error("Target retry does not mirror configuration done");

  chk_int_assert: assert property (
    (seq_cmd_write(`PEC_BIT_SET_INT) and add_on_mode)
    |=> int_pending && !inta_oe_n_out)
    else $error("INTA# not asserted after set command");

  chk_int_noaddon: assert property (
    (!add_on_mode && !int_pending) |=> !int_pending)
    else $error("INTA# set outside add-on mode");

  chk_int_readback: assert property (
    ctrl_rd |=> cpu_rdata_out[`PEC_BIT_SET_INT] == $past(int_pending))
    else $error("Bit 3 read did not return pending flag");

  chk_set_selfclr: assert property (
    (seq_cmd_write(`PEC_BIT_SET_INT) ##1 !ctrl_wr) |-> seq_pulse_then_drop)
    else $error("Interrupt command bit did not self-clear");

  chk_inta_negate: assert property (
    (pci_clr_evt && !set_int_evt) |=> inta_oe_n_out && !int_pending)
    else $error("PCI write did not negate INTA#");

  chk_nmi_serr: assert property (
    serr_seen |=> !nmi_n_out)
    else $error("NMI# not asserted on SERR#");

  chk_nmi_clear: assert property (
    (rst_nmi_evt && !serr_seen) |=> nmi_n_out)
    else $error("NMI# not negated by clear command");

  chk_nmi_bit_drop: assert property (
    (seq_cmd_write(`PEC_BIT_RST_NMI) ##1 !ctrl_wr)
    |-> rst_nmi_bit ##1 !rst_nmi_bit)
    else $error("NMI clear bit not stored for one clock");

  chk_aob_zero_hi: assert property (
    pci_aob_rdata_out[31:1] == 31'h0000_0000)
    else $error("Add-on register upper bits not zero");

  chk_rsvd_zero: assert property (
    cpu_rdata_out[31:`PEC_CTRL_USED_W] == 27'h000_0000)
    else $error("Reserved control bits not zero");

endmodule // pec_enable_control

// >>> logic/pec_params.svh
`ifndef PEC_PARAMS_SVH
`define PEC_PARAMS_SVH

// CPU-side register window
`define PEC_CPU_ADDR_W       8
`define PEC_OFS_ENABLE_CTRL  8'h74
`define PEC_CTRL_RESET       32'h0000_0000

// Enable control fields
`define PEC_BIT_ARB_ON       0
`define PEC_BIT_ADD_ON       1
`define PEC_BIT_CFG_DONE     2
`define PEC_BIT_SET_INT      3
`define PEC_BIT_RST_NMI      4
`define PEC_CTRL_USED_W      5

// Add-on interrupt register fields
`define PEC_BIT_INT_PEND     0
`define PEC_AOB_RESET        32'h0000_0000

`endif

// >>> logic/pec_pkg.sv
package pec_pkg;

  typedef logic [31:0] pec_word_t;

  typedef enum logic [1:0] {
    PEC_ACC_IDLE,
    PEC_ACC_READ,
    PEC_ACC_WRITE
  } pec_access_t;

endpackage

// >>> logic/pec_sync3.sv
`timescale 1ns/1ps

module pec_sync3 (
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a change only once two late stages agree
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_out <= 1'b1;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end

  chk_sync_agree: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (sync_out != $past(sync_out)) |-> ($past(stage2) == $past(stage3)))
    else $error("Synchroniser output moved without agreement");

endmodule // pec_sync3

// >>> logic/pec_pulse_bit.sv
`timescale 1ns/1ps

module pec_pulse_bit (
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic set_in,
  output logic      bit_out
);

  // Holds a written one for a single clock, then drops by itself
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_out <= 1'b0;
    end else begin
      bit_out <= set_in;
    end
  end

  chk_pulse_selfclr: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (bit_out && !set_in) |=> !bit_out)
    else $error("Self-clearing bit did not drop");

endmodule // pec_pulse_bit

// >>> tb/pec_pci_master_model.sv
`timescale 1ns/1ps

module pec_pci_master_model (
  input  wire logic        ref_clk_in,
  input  wire logic        aob_ack_in,
  input  wire logic [31:0] aob_rdata_in,
  output logic             aob_sel_out,
  output logic             aob_wr_out,
  output logic             serr_n_out
);
  initial begin
    aob_sel_out = 1'b0;
    aob_wr_out  = 1'b0;
    serr_n_out  = 1'b1;
  end

  // One strobe cycle; written data is irrelevant to the clear
  task automatic aob_access(input logic wr, output logic ack,
                            output logic [31:0] rd);
    @(posedge ref_clk_in);
    aob_sel_out <= 1'b1;
    aob_wr_out  <= wr;
    @(posedge ref_clk_in);
    aob_sel_out <= 1'b0;
    aob_wr_out  <= ~wr;
    #1;
    ack = aob_ack_in;
    rd  = aob_rdata_in;
  endtask

  // System error level, held until changed
  task automatic set_serr(input logic asserted);
    @(posedge ref_clk_in);
    serr_n_out <= ~asserted;
  endtask
endmodule // pec_pci_master_model

// >>> tb/pec_enable_control_tb.sv
`timescale 1ns/1ps

module pec_enable_control_tb
  import pec_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic       cpu_sel;
  logic       cpu_wr;
  logic [7:0] cpu_addr;
  logic [3:0] cpu_be;
  pec_word_t  cpu_wdata;
  logic       cpu_ack;
  pec_word_t  cpu_rdata;
  logic       aob_sel;
  logic       aob_wr;
  logic       aob_ack;
  pec_word_t  aob_rdata;
  logic       serr_n;
  logic       arb_on;
  logic       add_on;
  logic       retry;
  logic       inta_n;
  logic       inta_oe_n;
  logic       nmi_n;
  int         n_errors;
  int         n_checks;

  pec_enable_control i_dut (
    .ref_clk_in       (clk),
    .reset_n_in       (rst_n),
    .cpu_sel_in       (cpu_sel),
    .cpu_wr_in        (cpu_wr),
    .cpu_addr_in      (cpu_addr),
    .cpu_be_in        (cpu_be),
    .cpu_wdata_in     (cpu_wdata),
    .cpu_ack_out      (cpu_ack),
    .cpu_rdata_out    (cpu_rdata),
    .pci_aob_sel_in   (aob_sel),
    .pci_aob_wr_in    (aob_wr),
    .pci_aob_ack_out  (aob_ack),
    .pci_aob_rdata_out(aob_rdata),
    .serr_n_in        (serr_n),
    .arbiter_on_out   (arb_on),
    .add_on_mode_out  (add_on),
    .target_retry_out (retry),
    .inta_n_out       (inta_n),
    .inta_oe_n_out    (inta_oe_n),
    .nmi_n_out        (nmi_n)
  );

  pec_pci_master_model i_pci (
    .ref_clk_in  (clk),
    .aob_ack_in  (aob_ack),
    .aob_rdata_in(aob_rdata),
    .aob_sel_out (aob_sel),
    .aob_wr_out  (aob_wr),
    .serr_n_out  (serr_n)
  );

  always #4 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(string what, pec_word_t seen, pec_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single strobe cycle, answer sampled 1 ns after the take edge
  task automatic cpu_acc(logic wr, logic [7:0] addr, logic [3:0] be,
                         pec_word_t data, logic exp_ack,
                         output pec_word_t rd);
    @(posedge clk);
    cpu_sel   <= 1'b1;
    cpu_wr    <= wr;
    cpu_addr  <= addr;
    cpu_be    <= be;
    cpu_wdata <= data;
    @(posedge clk);
    cpu_sel   <= 1'b0;
    cpu_wdata <= ~data;
    #1;
    check("cpu ack", {31'h0, cpu_ack}, {31'h0, exp_ack});
    rd = cpu_rdata;
  endtask

  task automatic cpu_wr32(pec_word_t data);
    pec_word_t rd;
    cpu_acc(1'b1, 8'h74, 4'hF, data, 1'b1, rd);
  endtask

  task automatic cpu_rd_chk(pec_word_t exp);
    pec_word_t rd;
    cpu_acc(1'b0, 8'h74, 4'hF, 32'h0, 1'b1, rd);
    check("ctrl read", rd, exp);
  endtask

  task automatic pci_acc(logic wr, pec_word_t exp_rd);
    logic      ack;
    pec_word_t rd;
    i_pci.aob_access(wr, ack, rd);
    check("pci ack", {31'h0, ack}, 32'h1);
    if (!wr) check("aob read", rd, exp_rd);
  endtask

  task automatic wait_nmi(logic exp, int limit);
    int i;
    for (i = 0; i < limit && nmi_n !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    n_checks++;
    if (nmi_n !== exp) begin
      n_errors++;
      $display("BAD nmi wait expected %b seen %b", exp, nmi_n);
      finish_test();
    end
  endtask

  task automatic t_reset();
    check("outs", {arb_on, add_on, retry, inta_oe_n, nmi_n}, 5'b00111);
    cpu_rd_chk(32'h0);
  endtask

  task automatic t_fields();
    pec_word_t rd;
    cpu_wr32(32'hFFFF_FFE1);
    check("arb add retry", {arb_on, add_on, retry}, 3'b101);
    cpu_rd_chk(32'h1);
    cpu_acc(1'b1, 8'h70, 4'hF, 32'h7, 1'b0, rd);
    cpu_acc(1'b1, 8'h74, 4'hE, 32'h7, 1'b1, rd);
    cpu_rd_chk(32'h1);
    cpu_wr32(32'h0000_0005);
    check("retry", retry, 1'b0);
    cpu_wr32(32'h0000_000D);
    check("inta off mode", inta_oe_n, 1'b1);
    cpu_rd_chk(32'h5);
  endtask

  task automatic t_inta();
    cpu_wr32(32'h0000_0007);
    check("add on", add_on, 1'b1);
    cpu_wr32(32'h0000_000F);
    check("inta oe", inta_oe_n, 1'b0);
    check("inta level", inta_n, 1'b0);
    pci_acc(1'b0, 32'h1);
    cpu_rd_chk(32'hF);
    cpu_rd_chk(32'hF);
    pci_acc(1'b1, 32'h0);
    check("inta clear", inta_oe_n, 1'b1);
    pci_acc(1'b0, 32'h0);
    cpu_rd_chk(32'h7);
  endtask

  task automatic t_nmi();
    i_pci.set_serr(1'b1);
    wait_nmi(1'b0, 8);
    cpu_wr32(32'h0000_0017);
    repeat (3) @(posedge clk);
    #1;
    check("nmi held", nmi_n, 1'b0);
    i_pci.set_serr(1'b0);
    repeat (6) @(posedge clk);
    #1;
    check("nmi latched", nmi_n, 1'b0);
    cpu_wr32(32'h0000_0017);
    wait_nmi(1'b1, 3);
    cpu_rd_chk(32'h7);
  endtask

  initial begin
    clk       = 1'b0;
    rst_n     = 1'b0;
    cpu_sel   = 1'b0;
    cpu_wr    = 1'b0;
    cpu_addr  = 8'h00;
    cpu_be    = 4'h0;
    cpu_wdata = 32'h0;
    n_errors  = 0;
    n_checks  = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_fields();
    t_inta();
    t_nmi();
    finish_test();
  end
endmodule // pec_enable_control_tb
